//--- nirm_regs.sv
/*
  Node identity and ROM map register bank: identifier loaded once from a
  serial ROM or by host writes, ROM base mapping, failed posted write
  offset capture, and a sticky interrupt status with mask.
  Assumes an AXI4-Lite master on clk, a serial ROM shifting data on the
  falling edge of rom_sck, and link-side events on clk.
*/
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module nirm_regs (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rom_present,
  input  wire logic        rom_sdi,
  output logic             rom_sck,
  output logic             rom_cs,
  input  wire logic        rom_rd_valid,
  input  wire logic [47:0] rom_rd_offset,
  output logic             host_addr_valid,
  output logic [31:0]      host_addr,
  input  wire logic        pw_fail,
  input  wire logic [31:0] pw_fail_offset,
  output logic             irq
);
  // Pin synchronisers; first stage feeds only the second
  logic present_s1_q, present_s2_q, sdi_s1_q, sdi_s2_q;
  always_ff @(posedge clk) begin
    present_s1_q <= rom_present;
    present_s2_q <= present_s1_q;
    sdi_s1_q     <= rom_sdi;
    sdi_s2_q     <= sdi_s1_q;
  end
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        aw_take, w_take, ar_take, do_wr;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data, wr_mask;
  logic [3:0]  wr_strb;
  logic [31:0] id_upper_q, id_upper_d, id_lower_q, id_lower_d;
  logic [31:0] rom_base_q, rom_base_d, fail_low_q, fail_low_d;
  logic        lock_up_q, lock_up_d, lock_lo_q, lock_lo_d;
  logic [nirm_pkg::IRQ_W-1:0] status_q, status_d, mask_q, mask_d, events;
  logic        irq_q, irq_d;
  logic        haddr_v_q, haddr_v_d;
  logic [31:0] haddr_q, haddr_d;
  nirm_pkg::nirm_ld_t ld_q, ld_d;
  logic [5:0]  div_q, div_d;
  logic [6:0]  bit_q, bit_d;
  logic [63:0] shift_q, shift_d;
  logic        sck_q, sck_d, cs_q, cs_d;
  logic        host_ld_up, host_ld_lo, in_win;

  always_comb begin
    aw_take  = s_axi_awvalid & awready_q;
    w_take   = s_axi_wvalid & wready_q;
    ar_take  = s_axi_arvalid & arready_q;
    wr_addr  = aw_full_q ? aw_addr_q : s_axi_awaddr;
    wr_data  = w_full_q ? w_data_q : s_axi_wdata;
    wr_strb  = w_full_q ? w_strb_q : s_axi_wstrb;
    wr_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    do_wr    = (aw_full_q | aw_take) & (w_full_q | w_take) & ~bvalid_q;
    aw_full_d = (aw_full_q | aw_take) & ~do_wr;
    w_full_d  = (w_full_q | w_take) & ~do_wr;
    aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
    w_data_d  = w_take ? s_axi_wdata : w_data_q;
    w_strb_d  = w_take ? s_axi_wstrb : w_strb_q;
    bvalid_d  = do_wr | (bvalid_q & ~s_axi_bready);
    awready_d = ~aw_full_d & ~bvalid_d;
    wready_d  = ~w_full_d & ~bvalid_d;
    bresp_d   = bresp_q;
    if (do_wr) begin
      case (wr_addr)
        nirm_pkg::ADDR_ID_UPPER, nirm_pkg::ADDR_ID_LOWER,
        nirm_pkg::ADDR_ROM_BASE, nirm_pkg::ADDR_FAIL_LOW,
        nirm_pkg::ADDR_IRQ_STATUS, nirm_pkg::ADDR_IRQ_MASK,
        nirm_pkg::ADDR_LOAD_UPPER, nirm_pkg::ADDR_LOAD_LOWER:
          bresp_d = nirm_pkg::RESP_OKAY;
        default: bresp_d = nirm_pkg::RESP_SLVERR;
      endcase
    end
    rvalid_d  = ar_take | (rvalid_q & ~s_axi_rready);
    arready_d = ~rvalid_d;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (ar_take) begin
      rresp_d = nirm_pkg::RESP_OKAY;
      case (s_axi_araddr)
        nirm_pkg::ADDR_ID_UPPER:   rdata_d = id_upper_q;
        nirm_pkg::ADDR_ID_LOWER:   rdata_d = id_lower_q;
        nirm_pkg::ADDR_ROM_BASE:
          rdata_d = rom_base_q & nirm_pkg::ROM_BASE_MASK;
        nirm_pkg::ADDR_FAIL_LOW:   rdata_d = fail_low_q;
        nirm_pkg::ADDR_IRQ_STATUS: rdata_d = 32'(status_q);
        nirm_pkg::ADDR_IRQ_MASK:   rdata_d = 32'(mask_q);
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = nirm_pkg::RESP_SLVERR;
        end
      endcase
    end
  end
  // Host loads only when no ROM was found and the half is still open
  always_comb begin
    host_ld_up = do_wr & (wr_addr == nirm_pkg::ADDR_LOAD_UPPER)
                 & (ld_q == nirm_pkg::LD_HOST) & ~lock_up_q;
    host_ld_lo = do_wr & (wr_addr == nirm_pkg::ADDR_LOAD_LOWER)
                 & (ld_q == nirm_pkg::LD_HOST) & ~lock_lo_q;
    in_win     = (rom_rd_offset >= nirm_pkg::ROM_WIN_LO)
                 & (rom_rd_offset <= nirm_pkg::ROM_WIN_HI);
  end
  // Loader: strap settles, then 64 bits MSB first, upper quadlet first
  always_comb begin
    ld_d    = ld_q;
    div_d   = div_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    sck_d   = sck_q;
    cs_d    = cs_q;
    case (ld_q)
      nirm_pkg::LD_CHECK: begin
        div_d = div_q + 6'h01;
        if (div_q == nirm_pkg::SETTLE_CYC) begin
          div_d = 6'h00;
          if (present_s2_q) begin
            ld_d = nirm_pkg::LD_SHIFT;
            cs_d = 1'b1;
          end else begin
            ld_d = nirm_pkg::LD_HOST;
          end
        end
      end
      nirm_pkg::LD_SHIFT: begin
        div_d = div_q + 6'h01;
        if (div_q == nirm_pkg::SCK_HALF - 6'h01) begin
          div_d = 6'h00;
          sck_d = ~sck_q;
          // Sample at end of high phase; data has been stable since the last falling edge, a full period less two sync cycles
          if (sck_q) begin
            shift_d = {shift_q[62:0], sdi_s2_q};
            bit_d   = bit_q + 7'h01;
            if (bit_q == nirm_pkg::ID_BITS - 7'h01) begin
              ld_d = nirm_pkg::LD_ROM;
              cs_d = 1'b0;
            end
          end
        end
      end
      nirm_pkg::LD_ROM, nirm_pkg::LD_HOST: ld_d = ld_q;
      default:           ld_d = nirm_pkg::LD_CHECK;
    endcase
  end
  always_comb begin
    id_upper_d = id_upper_q;
    id_lower_d = id_lower_q;
    lock_up_d  = lock_up_q;
    lock_lo_d  = lock_lo_q;
    if (ld_q == nirm_pkg::LD_SHIFT && ld_d == nirm_pkg::LD_ROM) begin
      id_upper_d = shift_d[63:32];
      id_lower_d = shift_d[31:0];
      lock_up_d  = 1'b1;
      lock_lo_d  = 1'b1;
    end
    if (host_ld_up) begin
      id_upper_d = (id_upper_q & ~wr_mask) | (wr_data & wr_mask);
      lock_up_d  = 1'b1;
    end
    if (host_ld_lo) begin
      id_lower_d = (id_lower_q & ~wr_mask) | (wr_data & wr_mask);
      lock_lo_d  = 1'b1;
    end
    rom_base_d = rom_base_q;
    if (do_wr && wr_addr == nirm_pkg::ADDR_ROM_BASE) begin
      rom_base_d = ((rom_base_q & ~wr_mask) | (wr_data & wr_mask))
                   & nirm_pkg::ROM_BASE_MASK;
    end
    mask_d = mask_q;
    if (do_wr && wr_addr == nirm_pkg::ADDR_IRQ_MASK) begin
      mask_d = wr_data[nirm_pkg::IRQ_W-1:0];
    end
    fail_low_d = pw_fail ? pw_fail_offset : fail_low_q;
    haddr_v_d  = rom_rd_valid & in_win;
    haddr_d    = haddr_q;
    if (rom_rd_valid && in_win) begin
      haddr_d = (rom_base_q & nirm_pkg::ROM_BASE_MASK)
                + {22'h0,
                   rom_rd_offset[nirm_pkg::ROM_OFS_BITS-1:0]};
    end
    events = '0;
    events[nirm_pkg::IRQ_ID_LOADED]  = (lock_up_d & lock_lo_d)
                                       & ~(lock_up_q & lock_lo_q);
    events[nirm_pkg::IRQ_WRITE_FAIL] = pw_fail;
    events[nirm_pkg::IRQ_ROM_READ]   = rom_rd_valid & in_win;
    // Read clears, but an event in the same cycle survives
    status_d = status_q;
    if (ar_take && s_axi_araddr == nirm_pkg::ADDR_IRQ_STATUS) begin
      status_d = '0;
    end
    status_d = status_d | events;
    irq_d    = |(status_d & mask_d);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      bresp_q   <= nirm_pkg::RESP_OKAY;
      rresp_q   <= nirm_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      id_upper_q <= nirm_pkg::ID_UPPER_RST;
      id_lower_q <= nirm_pkg::ID_LOWER_RST;
      rom_base_q <= nirm_pkg::ROM_BASE_RST;
      lock_up_q <= 1'b0;
      lock_lo_q <= 1'b0;
      status_q  <= '0;
      mask_q    <= '0;
      irq_q     <= 1'b0;
      haddr_v_q <= 1'b0;
      haddr_q   <= 32'h0000_0000;
      ld_q      <= nirm_pkg::LD_CHECK;
      div_q     <= 6'h00;
      bit_q     <= 7'h00;
      sck_q     <= 1'b0;
      cs_q      <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      bresp_q   <= bresp_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      id_upper_q <= id_upper_d;
      id_lower_q <= id_lower_d;
      rom_base_q <= rom_base_d;
      lock_up_q <= lock_up_d;
      lock_lo_q <= lock_lo_d;
      status_q  <= status_d;
      mask_q    <= mask_d;
      irq_q     <= irq_d;
      haddr_v_q <= haddr_v_d;
      haddr_q   <= haddr_d;
      ld_q      <= ld_d;
      div_q     <= div_d;
      bit_q     <= bit_d;
      sck_q     <= sck_d;
      cs_q      <= cs_d;
    end
  end
  // Not reset: undefined until a failure, or always loaded before use
  always_ff @(posedge clk) begin
    fail_low_q <= fail_low_d;
    aw_addr_q  <= aw_addr_d;
    w_data_q   <= w_data_d;
    w_strb_q   <= w_strb_d;
    shift_q    <= shift_d;
  end
  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  assign s_axi_rvalid    = rvalid_q;
  assign rom_sck         = sck_q;
  assign rom_cs          = cs_q;
  assign host_addr_valid = haddr_v_q;
  assign host_addr       = haddr_q;
  assign irq             = irq_q;
  sequence s_rd_upper;
    ar_take && s_axi_araddr == nirm_pkg::ADDR_ID_UPPER;
  endsequence
  sequence s_win_read;
    rom_rd_valid && in_win;
  endsequence
  a_upper_reset_zero: assert property (@(posedge clk)
    $past(srst) |-> id_upper_q == 32'h0000_0000)
    else $error("upper identifier not zero after reset");
  a_rom_fill_lock: assert property (@(posedge clk) disable iff (srst)
    (ld_q == nirm_pkg::LD_SHIFT && ld_d == nirm_pkg::LD_ROM) |=>
    lock_up_q && lock_lo_q && id_lower_q == $past(shift_d[31:0]))
    else $error("ROM load did not fill and lock identifier");
  a_locked_stable: assert property (@(posedge clk) disable iff (srst)
    lock_up_q && lock_lo_q |=> $stable(id_upper_q) && $stable(id_lower_q))
    else $error("locked identifier changed");
  a_host_upper_load: assert property (@(posedge clk) disable iff (srst)
    host_ld_up && wr_strb == 4'hf |=> id_upper_q == $past(wr_data))
    else $error("host upper load not taken");
  a_host_lower_load: assert property (@(posedge clk) disable iff (srst)
    host_ld_lo && wr_strb == 4'hf |=> id_lower_q == $past(wr_data))
    else $error("host lower load not taken");
  a_upper_read_back: assert property (@(posedge clk) disable iff (srst)
    s_rd_upper |=> s_axi_rvalid && s_axi_rdata == $past(id_upper_q))
    else $error("upper identifier read wrong");
  a_upper_fields: assert property (@(posedge clk) disable iff (srst)
    s_rd_upper |=> s_axi_rdata[nirm_pkg::MAKER_MSB:nirm_pkg::MAKER_LSB]
      == $past(id_upper_q[nirm_pkg::MAKER_MSB:nirm_pkg::MAKER_LSB]))
    else $error("maker field misplaced");
  a_lower_reset_zero: assert property (@(posedge clk)
    $past(srst) |-> id_lower_q == 32'h0000_0000)
    else $error("lower identifier not zero after reset");
  a_host_addr_form: assert property (@(posedge clk) disable iff (srst)
    s_win_read |=> host_addr_valid && host_addr ==
      {$past(rom_base_q[31:10]), $past(rom_rd_offset[9:0])})
    else $error("host address not formed");
  a_base_low_zero: assert property (@(posedge clk) disable iff (srst)
    rom_base_q[9:0] == 10'h000)
    else $error("ROM base low bits not zero");
  a_fail_capture: assert property (@(posedge clk) disable iff (srst)
    pw_fail |=> fail_low_q == $past(pw_fail_offset))
    else $error("failed offset not captured");
endmodule

//--- nirm_pkg.sv
/*
  Constants, register map and states for the node identity and ROM map
  register bank.
  Assumes a 40 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// Functional notes
// - Reset clears upper identifier to zero, which is an invalid identifier.
// - With serial ROM present, identifier is loaded from it after reset.
// - Once loaded, by ROM or host, identifier writes are ignored.
// - Without ROM, host write to offset 0x80 loads upper identifier.
// - Without ROM, host write to offset 0x84 loads lower identifier.
// - Upper identifier register returns upper 32 identifier bits.
// - Upper register: maker part in 31:8, serial high byte 7:0, read-only.
// - Lower identifier register returns low serial word, zero after reset.
// - ROM-window quadlet read forms host address as base plus low 10 bits.
// - ROM base keeps writable bits 31:10, bits 9:0 read zero.
// - Failed posted write updates failed-offset register; reset undefined.
// - Failed-offset register captures low 32 destination offset bits.
package nirm_pkg;
  localparam logic [7:0]  ADDR_ID_UPPER    = 8'h24;
  localparam logic [7:0]  ADDR_ID_LOWER    = 8'h28;
  localparam logic [7:0]  ADDR_ROM_BASE    = 8'h34;
  localparam logic [7:0]  ADDR_FAIL_LOW    = 8'h38;
  localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h60;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h64;
  localparam logic [7:0]  ADDR_LOAD_UPPER  = 8'h80;
  localparam logic [7:0]  ADDR_LOAD_LOWER  = 8'h84;

  localparam logic [31:0] ID_UPPER_RST     = 32'h0000_0000;
  localparam logic [31:0] ID_LOWER_RST     = 32'h0000_0000;
  localparam logic [31:0] ROM_BASE_RST     = 32'h0000_0000;
  localparam logic [31:0] ROM_BASE_MASK    = 32'hffff_fc00;
  localparam int          MAKER_MSB        = 31;
  localparam int          MAKER_LSB        = 8;
  localparam int          SERIAL_HI_MSB    = 7;
  localparam int          ROM_OFS_BITS     = 10;

  localparam logic [47:0] ROM_WIN_LO       = 48'hffff_f000_0400;
  localparam logic [47:0] ROM_WIN_HI       = 48'hffff_f000_07ff;

  localparam int          IRQ_W            = 3;
  localparam int          IRQ_ID_LOADED    = 0;
  localparam int          IRQ_WRITE_FAIL   = 1;
  localparam int          IRQ_ROM_READ     = 2;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          SCK_PERIOD_NS    = 1000;
  localparam int          SCK_HALF_CYC     = SCK_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam logic [5:0]  SCK_HALF         = 6'(SCK_HALF_CYC);
  localparam logic [5:0]  SETTLE_CYC       = 6'h04;
  localparam logic [6:0]  ID_BITS          = 7'h40;

  typedef enum logic [1:0] {
    LD_CHECK = 2'b00,
    LD_SHIFT = 2'b01,
    LD_ROM   = 2'b10,
    LD_HOST  = 2'b11
  } nirm_ld_t;
endpackage

//--- nirm_rom_model.sv
/*
  Behavioural serial ROM at the far side of the identifier loader.
  Assumes the loader frames a load with rom_cs and samples each bit
  while rom_sck is high; data changes on rom_cs edges and otherwise only on the falling edge of rom_sck.
*/
`timescale 1ns/1ps
module nirm_rom_model #(
  // Arbitrary identifier contents
  parameter logic [63:0] CONTENT = 64'h0123_4567_89ab_cdef
) (
  input  wire logic rom_cs,
  input  wire logic rom_sck,
  output logic      rom_sdi
);
  int idx;

  initial begin
    rom_sdi = 1'b0;
    idx = 63;
  end

  // MSB first, upper quadlet before lower
  always @(posedge rom_cs) begin
    idx = 63;
    rom_sdi = CONTENT[63];
  end

  always @(negedge rom_sck) begin
    if (rom_cs && idx > 0) begin
      idx = idx - 1;
      rom_sdi = CONTENT[idx];
    end
  end

  // No pull on the line: show the inverse once released
  always @(negedge rom_cs) begin
    rom_sdi = ~rom_sdi;
  end
endmodule

//--- tb.sv
/*
  Self-checking bench for the node identity and ROM map register bank.
  Assumes nirm_pkg, nirm_regs and nirm_rom_model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  // Arbitrary identifier held in the serial ROM model
  localparam logic [63:0] ROM_ID = 64'h0123_4567_89ab_cdef;
  logic        clk;
  logic        srst;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        rom_present;
  logic        rom_sdi;
  logic        rom_sck;
  logic        rom_cs;
  logic        rom_rd_valid;
  logic [47:0] rom_rd_offset;
  logic        host_addr_valid;
  logic [31:0] host_addr;
  logic        pw_fail;
  logic [31:0] pw_fail_offset;
  logic        irq;
  logic [1:0]  b_q[$];
  logic [31:0] r_q[$];
  logic [1:0]  rr_q[$];
  logic [31:0] h_q[$];
  logic [31:0] base;
  int          n_fail;
  int          num_checks;
  int          cyc;
  int          n_sck;

  nirm_regs u_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rom_present, .rom_sdi,
    .rom_sck, .rom_cs, .rom_rd_valid, .rom_rd_offset, .host_addr_valid,
    .host_addr, .pw_fail, .pw_fail_offset, .irq);

  nirm_rom_model #(.CONTENT(ROM_ID)) u_rom (.rom_cs, .rom_sck, .rom_sdi);

  // Serial clock pulses seen inside a load frame
  always @(posedge rom_sck)
    if (rom_cs) n_sck++;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Results are compared where they appear, against the oldest note
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
    if (!srst && s_axi_bvalid && s_axi_bready)
      chk("bresp", {30'h0, b_q.pop_front()}, {30'h0, s_axi_bresp});
    if (!srst && s_axi_rvalid && s_axi_rready) begin
      chk("rdata", r_q.pop_front(), s_axi_rdata);
      chk("rresp", {30'h0, rr_q.pop_front()}, {30'h0, s_axi_rresp});
    end
    if (!srst && host_addr_valid) begin
      if (h_q.size() == 0) chk("host_addr_valid", 32'h0, 32'h1);
      else chk("host_addr", h_q.pop_front(), host_addr);
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    bit aw_p;
    bit w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_q.push_back(er);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    bit ar_p;
    ar_p = 1'b1;
    r_q.push_back(e);
    rr_q.push_back(er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar_p && s_axi_arready) begin
        ar_p = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rom_req(input logic [47:0] o, input bit hit);
    if (hit) h_q.push_back((base & 32'hffff_fc00) + {22'h0, o[9:0]});
    rom_rd_valid <= 1'b1;
    rom_rd_offset <= o;
    @(posedge clk);
  endtask

  task automatic pw_event(input logic [31:0] o);
    pw_fail <= 1'b1;
    pw_fail_offset <= o;
    @(posedge clk);
    pw_fail <= 1'b0;
    @(posedge clk);
  endtask

  task automatic irq_is(input logic e);
    repeat (4) @(posedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic do_reset(input logic rp);
    srst <= 1'b1;
    rom_present <= rp;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    logic [31:0] u;
    logic [31:0] l;
    logic [31:0] d;
    {srst, rom_present, pw_fail, rom_rd_valid} = 4'h8;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
    {s_axi_wdata, pw_fail_offset, rom_rd_offset} = 112'h0;
    void'($urandom(10966));
    base = 32'h0;
    do_reset(1'b0);
    axi_rd(8'h24, 32'h0, 2'h0);
    axi_rd(8'h28, 32'h0, 2'h0);
    axi_rd(8'h34, 32'h0, 2'h0);
    axi_rd(8'h64, 32'h0, 2'h0);
    repeat (8) @(posedge clk);
    u = $urandom;
    l = $urandom;
    axi_wr(8'h80, u, 4'hf, 2'h0);
    axi_wr(8'h84, l, 4'hf, 2'h0);
    axi_wr(8'h80, ~u, 4'hf, 2'h0);
    axi_wr(8'h84, ~l, 4'hf, 2'h0);
    axi_wr(8'h24, ~u, 4'hf, 2'h0);
    axi_rd(8'h24, u, 2'h0);
    axi_rd(8'h28, l, 2'h0);
    axi_wr(8'h90, u, 4'hf, 2'h2);
    axi_rd(8'h90, 32'h0, 2'h2);
    axi_rd(8'h80, 32'h0, 2'h2);
    d = $urandom;
    axi_wr(8'h34, d, 4'hf, 2'h0);
    base = d & 32'hffff_fc00;
    axi_rd(8'h34, base, 2'h0);
    d = $urandom;
    axi_wr(8'h34, d, 4'h8, 2'h0);
    base = {d[31:24], base[23:0]};
    axi_rd(8'h34, base, 2'h0);
    // Back to back, both window edges and just outside them
    rom_req(48'hffff_f000_0400, 1'b1);
    rom_req(48'hffff_f000_07ff, 1'b1);
    rom_req(48'hffff_f000_0400 + 48'($urandom_range(1023)), 1'b1);
    rom_req(48'hffff_f000_03ff, 1'b0);
    rom_req(48'hffff_f000_0800, 1'b0);
    rom_req(48'h0000_f000_0400, 1'b0);
    rom_rd_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pending host_addr", 32'h0, h_q.size());
    d = $urandom;
    pw_event(d);
    axi_wr(8'h38, ~d, 4'hf, 2'h0);
    axi_rd(8'h38, d, 2'h0);
    axi_wr(8'h64, 32'h2, 4'hf, 2'h0);
    irq_is(1'b1);
    axi_rd(8'h60, 32'h7, 2'h0);
    irq_is(1'b0);
    axi_rd(8'h64, 32'h2, 2'h0);
    pw_event(~d);
    irq_is(1'b1);
    axi_wr(8'h64, 32'h0, 4'hf, 2'h0);
    irq_is(1'b0);
    axi_rd(8'h60, 32'h2, 2'h0);
    axi_rd(8'h38, ~d, 2'h0);
    do_reset(1'b1);
    axi_rd(8'h24, 32'h0, 2'h0);
    while (!rom_cs) @(posedge clk);
    while (rom_cs) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("rom_sck pulses", 32'h40, n_sck);
    chk("rom_cs idle", 32'h0, {31'h0, rom_cs});
    chk("rom_sck idle", 32'h0, {31'h0, rom_sck});
    axi_rd(8'h24, ROM_ID[63:32], 2'h0);
    axi_rd(8'h28, ROM_ID[31:0], 2'h0);
    axi_wr(8'h80, ~u, 4'hf, 2'h0);
    axi_rd(8'h24, ROM_ID[63:32], 2'h0);
    axi_rd(8'h60, 32'h1, 2'h0);
    report_and_stop();
  end
endmodule
